//--- core/pmu_regs.vh
`ifndef PMU_REGS_VH
`define PMU_REGS_VH
// Power mode control register and its fields
`define PMC_ADDR        8'h87
`define PMC_RESET       8'h00
`define PMC_IDLE_BIT    0
`define PMC_PDOWN_BIT   1
`define PMC_FLAG_LO_BIT 2
`define PMC_FLAG_HI_BIT 3
// Wake/interrupt configuration register
`define WCFG_ADDR       8'h88
`define WCFG_RESET      8'h00
`define WCFG_EXT0_BIT   0
`define WCFG_EXT1_BIT   1
`define WCFG_WAKE_BIT   4
`define WCFG_GLOBAL_BIT 7
// Status register (read only)
`define STAT_ADDR       8'h89
`define STAT_IDLE_BIT   0
`define STAT_PDOWN_BIT  1
`define STAT_SETTLE_BIT 2
`define STAT_WAKE0_BIT  4
`define STAT_WAKE1_BIT  5
`define STAT_RESET_BIT  6
// Mode encodings
`define MODE_RUN        2'h0
`define MODE_IDLE       2'h1
`define MODE_PDOWN      2'h2
`define MODE_SETTLE     2'h3
// Clock settle count after oscillator restart
`define SETTLE_CYCLES   1024
`endif

//--- core/pin_sync.v
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // Asynchronous pin and its synchronised copy
    input  wire pin_i,
    output reg  sync_o
);
    reg meta_reg;

    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            sync_o   <= 1'b0;
        end else begin
            meta_reg <= pin_i;
            sync_o   <= meta_reg;
        end
    end
endmodule // pin_sync

//--- core/settle_counter.v
`timescale 1ns/1ps
module settle_counter #(
    parameter CYCLES = 1024,
    parameter WIDTH  = 11
) (
    // Clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // Start pulse, busy level and one-cycle completion pulse
    input  wire start_i,
    output reg  busy_o,
    output reg  done_o
);
    reg [WIDTH-1:0] count_reg;

    always @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= {WIDTH{1'b0}};
            busy_o    <= 1'b0;
            done_o    <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                // Start edge is the first settle cycle, so load one
                count_reg <= {{(WIDTH-1){1'b0}}, 1'b1};
                busy_o    <= 1'b1;
            end else if (busy_o) begin
                if (count_reg == CYCLES[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // settle_counter

//--- core/power_mode_unit.v
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "pmu_regs.vh"
module power_mode_unit #(
    parameter SETTLE_CYCLES = `SETTLE_CYCLES,
    parameter SETTLE_WIDTH  = 11
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Pins
    input  wire        reset_pin_i,
    input  wire        ext_irq_pin0_i,
    input  wire        ext_irq_pin1_i,
    input  wire        ext_prog_mem_i,
    // Interrupt logic
    input  wire        irq_pending_i,
    // Clock control and core
    output reg         cpu_clk_en_o,
    output reg         periph_clk_en_o,
    output reg         osc_en_o,
    output reg         core_reset_o,
    output reg         wake_irq0_o,
    output reg         wake_irq1_o,
    // Strobe and port control
    output reg         addr_latch_o,
    output reg         program_fetch_strobe_o,
    output reg         port0_oe_o,
    output reg         port2_addr_sel_o,
    output reg         pins_forced_o,
    // Mode status
    output reg  [1:0]  mode_o
);
    reg       user_flag_hi_reg;
    reg       user_flag_lo_reg;
    reg       global_irq_enable_reg;
    reg       ext_irq0_enable_reg;
    reg       ext_irq1_enable_reg;
    reg       powerdown_wake_enable_reg;
    reg [1:0] mode_reg;
    reg [1:0] mode_next;
    reg       wake0_reg;
    reg       wake1_reg;
    reg       reset_wake_reg;
    reg       wake0_next;
    reg       wake1_next;
    // Reset image of the control register, sliced per flag
    localparam [7:0] PMC_RESET_VALUE = `PMC_RESET;

    wire      reset_sync;
    wire      irq0_sync;
    wire      irq1_sync;
    wire      settle_busy;
    wire      settle_done;
    wire      bus_req;
    wire      wr_lane0;
    wire      idle_req;
    wire      pdown_req;
    wire      pin_wake0;
    wire      pin_wake1;
    wire      start_settle;

    // Sync copies keep metastability out of the wake decode
    pin_sync u_sync_reset (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pin_i (reset_pin_i),
        .sync_o(reset_sync)
    );

    pin_sync u_sync_irq0 (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pin_i (ext_irq_pin0_i),
        .sync_o(irq0_sync)
    );

    pin_sync u_sync_irq1 (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pin_i (ext_irq_pin1_i),
        .sync_o(irq1_sync)
    );

    // Oscillator restarted by a pin wake is not trusted until the count runs out
    settle_counter #(
        .CYCLES(SETTLE_CYCLES),
        .WIDTH (SETTLE_WIDTH)
    ) u_settle (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .start_i(start_settle),
        .busy_o (settle_busy),
        .done_o (settle_done)
    );

    assign bus_req   = cyc_i & stb_i & ~ack_o;
    // Writes land at the edge that samples ack high, where the master
    // lets go of the request; earlier would commit an unanswered cycle
    assign wr_lane0  = cyc_i & stb_i & ack_o & we_i & sel_i[0];
    assign idle_req  = wr_lane0 && adr_i == `PMC_ADDR
                       && dat_i[`PMC_IDLE_BIT];
    assign pdown_req = wr_lane0 && adr_i == `PMC_ADDR
                       && dat_i[`PMC_PDOWN_BIT];

    // Pin wake needs all three enables
    assign pin_wake0 = irq0_sync & global_irq_enable_reg & ext_irq0_enable_reg
                       & powerdown_wake_enable_reg;
    assign pin_wake1 = irq1_sync & global_irq_enable_reg & ext_irq1_enable_reg
                       & powerdown_wake_enable_reg;
    assign start_settle = (mode_reg == `MODE_PDOWN) & (pin_wake0 | pin_wake1)
                          & ~reset_sync;

    always @* begin
        mode_next  = mode_reg;
        wake0_next = wake0_reg;
        wake1_next = wake1_reg;
        case (mode_reg)
            `MODE_RUN: begin
                // Power-down wins if both are written at once
                if (pdown_req) begin
                    mode_next = `MODE_PDOWN;
                end else if (idle_req) begin
                    mode_next = `MODE_IDLE;
                end
            end
            `MODE_IDLE: begin
                // Pending input is already masked per source upstream
                if (irq_pending_i & global_irq_enable_reg) begin
                    mode_next = `MODE_RUN;
                end
            end
            `MODE_PDOWN: begin
                if (start_settle) begin
                    mode_next  = `MODE_SETTLE;
                    // Pin 0 wins when both pins wake at once
                    wake0_next = pin_wake0;
                    wake1_next = pin_wake1 & ~pin_wake0;
                end
            end
            `MODE_SETTLE: begin
                // Done arrives so that settle lasts exactly SETTLE_CYCLES
                if (settle_done) begin
                    mode_next = `MODE_RUN;
                end
            end
            // All four encodings are used; default only catches unknown values and falls back to run
            default: begin
                mode_next = `MODE_RUN;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg       <= `MODE_RUN;
            wake0_reg      <= 1'b0;
            wake1_reg      <= 1'b0;
            reset_wake_reg <= 1'b0;
        end else if (reset_sync) begin
            // Pin reset ends any mode; core restarts at address zero
            mode_reg       <= `MODE_RUN;
            wake0_reg      <= 1'b0;
            wake1_reg      <= 1'b0;
            // Sticky until rst_i so software can tell a reset wake-up
            reset_wake_reg <= (mode_reg == `MODE_PDOWN) | reset_wake_reg;
        end else begin
            mode_reg  <= mode_next;
            wake0_reg <= wake0_next;
            wake1_reg <= wake1_next;
        end
    end

    // Registers keep contents across power-down
    always @(posedge clk_i) begin
        if (rst_i) begin
            user_flag_hi_reg          <= PMC_RESET_VALUE[`PMC_FLAG_HI_BIT];
            user_flag_lo_reg          <= PMC_RESET_VALUE[`PMC_FLAG_LO_BIT];
            global_irq_enable_reg     <= 1'b0;
            ext_irq0_enable_reg       <= 1'b0;
            ext_irq1_enable_reg       <= 1'b0;
            powerdown_wake_enable_reg <= 1'b0;
        // Only lane 0 carries the 8-bit registers
        end else if (wr_lane0) begin
            if (adr_i == `PMC_ADDR) begin
                user_flag_hi_reg <= dat_i[`PMC_FLAG_HI_BIT];
                user_flag_lo_reg <= dat_i[`PMC_FLAG_LO_BIT];
            end
            if (adr_i == `WCFG_ADDR) begin
                global_irq_enable_reg     <= dat_i[`WCFG_GLOBAL_BIT];
                ext_irq0_enable_reg       <= dat_i[`WCFG_EXT0_BIT];
                ext_irq1_enable_reg       <= dat_i[`WCFG_EXT1_BIT];
                powerdown_wake_enable_reg <= dat_i[`WCFG_WAKE_BIT];
            end
        end
    end

    // Bus answer one cycle after request; unmapped reads give zero
    // Registered ack costs a cycle but keeps the decode off ack_o
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= bus_req;
            dat_o <= 32'h00000000;
            if (bus_req & ~we_i) begin
                case (adr_i)
                    `PMC_ADDR: begin
                        // Request bits always read zero
                        dat_o[`PMC_FLAG_HI_BIT] <= user_flag_hi_reg;
                        dat_o[`PMC_FLAG_LO_BIT] <= user_flag_lo_reg;
                    end
                    `WCFG_ADDR: begin
                        dat_o[`WCFG_GLOBAL_BIT] <= global_irq_enable_reg;
                        dat_o[`WCFG_EXT0_BIT]   <= ext_irq0_enable_reg;
                        dat_o[`WCFG_EXT1_BIT]   <= ext_irq1_enable_reg;
                        dat_o[`WCFG_WAKE_BIT]   <= powerdown_wake_enable_reg;
                    end
                    `STAT_ADDR: begin
                        dat_o[`STAT_IDLE_BIT]   <= mode_reg == `MODE_IDLE;
                        dat_o[`STAT_PDOWN_BIT]  <= mode_reg == `MODE_PDOWN;
                        dat_o[`STAT_SETTLE_BIT] <= settle_busy;
                        dat_o[`STAT_WAKE0_BIT]  <= wake0_reg;
                        dat_o[`STAT_WAKE1_BIT]  <= wake1_reg;
                        dat_o[`STAT_RESET_BIT]  <= reset_wake_reg;
                    end
                    default: begin
                        dat_o <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // Outputs registered from the next mode so they track the state
    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_o                 <= `MODE_RUN;
            cpu_clk_en_o           <= 1'b1;
            periph_clk_en_o        <= 1'b1;
            osc_en_o               <= 1'b1;
            core_reset_o           <= 1'b1;
            wake_irq0_o            <= 1'b0;
            wake_irq1_o            <= 1'b0;
            addr_latch_o           <= 1'b0;
            program_fetch_strobe_o <= 1'b0;
            port0_oe_o             <= 1'b1;
            port2_addr_sel_o       <= 1'b0;
            pins_forced_o          <= 1'b0;
        end else begin
            mode_o          <= reset_sync ? `MODE_RUN : mode_next;
            core_reset_o    <= reset_sync;
            cpu_clk_en_o    <= reset_sync | mode_next == `MODE_RUN;
            periph_clk_en_o <= reset_sync | mode_next == `MODE_RUN
                               | mode_next == `MODE_IDLE;
            osc_en_o        <= reset_sync | mode_next != `MODE_PDOWN;
            // One-cycle vector request into the matching service routine
            wake_irq0_o     <= settle_done & wake0_reg;
            wake_irq1_o     <= settle_done & wake1_reg;
            if (!reset_sync && mode_next == `MODE_IDLE) begin
                addr_latch_o           <= 1'b1;
                program_fetch_strobe_o <= 1'b1;
                // Strap is static, so it is read without synchronising
                port0_oe_o             <= ~ext_prog_mem_i;
                port2_addr_sel_o       <= ext_prog_mem_i;
                pins_forced_o          <= 1'b1;
            end else if (!reset_sync && mode_next != `MODE_RUN) begin
                addr_latch_o           <= 1'b0;
                program_fetch_strobe_o <= 1'b0;
                port0_oe_o             <= ~ext_prog_mem_i;
                port2_addr_sel_o       <= 1'b0;
                pins_forced_o          <= 1'b1;
            end else begin
                addr_latch_o           <= 1'b0;
                program_fetch_strobe_o <= 1'b0;
                port0_oe_o             <= 1'b1;
                port2_addr_sel_o       <= 1'b0;
                pins_forced_o          <= 1'b0;
            end
        end
    end
endmodule // power_mode_unit

//--- sim/pmu_far_side.sv
`timescale 1ns/1ps
module pmu_far_side #(
    // Short stand-in for the long reset hold, to keep runs brief
    parameter [7:0] HOLD_CYCLES = 8'h28
) (
    // Clock and requests from the bench
    input  wire       clk_i,
    input  wire       reset_req_i,
    input  wire       irq_req_i,
    input  wire       pin0_req_i,
    input  wire       pin1_req_i,
    // Pins and interrupt logic
    output wire       reset_pin_o,
    output reg        ext_irq_pin0_o = 1'b0,
    output reg        ext_irq_pin1_o = 1'b0,
    output reg        irq_pending_o = 1'b0
);
    reg [7:0] hold_reg = 8'h00;
    // A short pulse would leave the restarted clock unsettled
    always @(posedge clk_i) begin
        if (reset_req_i)
            hold_reg <= HOLD_CYCLES;
        else if (hold_reg != 8'h00)
            hold_reg <= hold_reg - 8'h01;
        ext_irq_pin0_o <= pin0_req_i;
        ext_irq_pin1_o <= pin1_req_i;
        irq_pending_o <= irq_req_i;
    end
    assign reset_pin_o = (hold_reg != 8'h00);
endmodule // pmu_far_side

//--- sim/pmu_checker_assertions.sv
`timescale 1ns/1ps
`include "pmu_regs.vh"
module pmu_checker #(
    parameter SETTLE_CYCLES = 8
) (
    // Clock, reset, bus
    input wire        clk_i,
    input wire        rst_i,
    input wire        we_i,
    input wire [7:0]  adr_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    // Pins and mode outputs
    input wire        reset_pin_i,
    input wire        ext_prog_mem_i,
    input wire        cpu_clk_en_o,
    input wire        periph_clk_en_o,
    input wire        osc_en_o,
    input wire        core_reset_o,
    input wire        wake_irq0_o,
    input wire        wake_irq1_o,
    input wire        addr_latch_o,
    input wire        program_fetch_strobe_o,
    input wire        port0_oe_o,
    input wire        port2_addr_sel_o,
    input wire [1:0]  mode_o
);
    reg [15:0] cnt_reg;
    reg [2:0]  pin_hist_reg;
    wire       quiet = (pin_hist_reg == 3'h0) && !reset_pin_i;
    always @(posedge clk_i) begin
        pin_hist_reg <= {pin_hist_reg[1:0], reset_pin_i};
        if (rst_i || mode_o != `MODE_SETTLE)
            cnt_reg <= 16'h0000;
        else
            cnt_reg <= cnt_reg + 16'h0001;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_req_bits_zero: assert property (ack_o && !we_i && adr_i == `PMC_ADDR
        |-> dat_o[1:0] == 2'h0 && dat_o[31:4] == 28'h0) else $error("request bits read back");
    a_idle_clocks: assert property (mode_o == `MODE_IDLE
        |-> !cpu_clk_en_o && periph_clk_en_o && osc_en_o) else $error("idle clock gating wrong");
    a_pdown_osc: assert property (mode_o == `MODE_PDOWN
        |-> !osc_en_o && !cpu_clk_en_o && !periph_clk_en_o) else $error("oscillator not stopped");
    a_idle_pins: assert property (mode_o == `MODE_IDLE |-> addr_latch_o
        && program_fetch_strobe_o && port2_addr_sel_o == ext_prog_mem_i
        && port0_oe_o != ext_prog_mem_i) else $error("idle pin state wrong");
    a_pdown_pins: assert property (mode_o == `MODE_PDOWN |-> !addr_latch_o
        && !program_fetch_strobe_o && !port2_addr_sel_o
        && port0_oe_o != ext_prog_mem_i) else $error("power-down pin state wrong");
    a_settle_len: assert property ($past(mode_o) == `MODE_SETTLE
        && mode_o != `MODE_SETTLE && quiet |-> cnt_reg == SETTLE_CYCLES)
        else $error("settle length wrong");
    a_pin_wake_settles: assert property ($past(mode_o) == `MODE_PDOWN
        && mode_o != `MODE_PDOWN && quiet |-> mode_o == `MODE_SETTLE)
        else $error("pin wake skipped settle");
    a_wake_pulse: assert property (wake_irq0_o || wake_irq1_o
        |-> mode_o == `MODE_RUN && !(wake_irq0_o && wake_irq1_o) ##1 !wake_irq0_o && !wake_irq1_o)
        else $error("wake vector pulse wrong");
    a_reset_pin: assert property (reset_pin_i [*6]
        |-> mode_o == `MODE_RUN && core_reset_o) else $error("reset pin ignored");
    c_idle: cover property (mode_o == `MODE_IDLE);
    c_settle: cover property (mode_o == `MODE_SETTLE);
    c_wake0: cover property (wake_irq0_o);
endmodule // pmu_checker
bind power_mode_unit pmu_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .reset_pin_i(reset_pin_i), .ext_prog_mem_i(ext_prog_mem_i), .cpu_clk_en_o(cpu_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .osc_en_o(osc_en_o), .core_reset_o(core_reset_o),
    .wake_irq0_o(wake_irq0_o), .wake_irq1_o(wake_irq1_o), .addr_latch_o(addr_latch_o),
    .program_fetch_strobe_o(program_fetch_strobe_o), .port0_oe_o(port0_oe_o),
    .port2_addr_sel_o(port2_addr_sel_o), .mode_o(mode_o));

//--- sim/test_power_mode_unit.sv
`timescale 1ns/1ps
`include "pmu_regs.vh"
module test_power_mode_unit;
    localparam SETTLE = 8;
    reg         clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    reg  [7:0]  adr_i = 8'h00;
    reg  [3:0]  sel_i = 4'h0;
    reg  [31:0] dat_i = 32'h0, q;
    reg         rq_rst = 1'b0, rq_irq = 1'b0, rq_p0 = 1'b0, rq_p1 = 1'b0;
    reg         seen0 = 1'b0, seen1 = 1'b0, ext_mem = 1'b1;
    reg  [28:0] rows [0:7];
    integer     miscompares = 0, n_checks = 0, i, n;
    wire [31:0] dat_o;
    wire [1:0]  mode_o;
    wire        ack_o, rpin, pin0, pin1, irqp, cpu_en, per_en, osc_en, core_rst, wk0, wk1;
    wire        latch, strobe, p0_oe, p2_sel, forced;
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (wk0 === 1'b1) seen0 <= 1'b1;
        if (wk1 === 1'b1) seen1 <= 1'b1;
    end
    power_mode_unit #(.SETTLE_CYCLES(SETTLE)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .reset_pin_i(rpin), .ext_irq_pin0_i(pin0),
        .ext_irq_pin1_i(pin1), .ext_prog_mem_i(ext_mem), .irq_pending_i(irqp),
        .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en), .osc_en_o(osc_en),
        .core_reset_o(core_rst), .wake_irq0_o(wk0), .wake_irq1_o(wk1), .addr_latch_o(latch),
        .program_fetch_strobe_o(strobe), .port0_oe_o(p0_oe), .port2_addr_sel_o(p2_sel),
        .pins_forced_o(forced), .mode_o(mode_o));
    pmu_far_side i_far (.clk_i(clk_i), .reset_req_i(rq_rst), .irq_req_i(rq_irq),
        .pin0_req_i(rq_p0), .pin1_req_i(rq_p1), .reset_pin_o(rpin), .ext_irq_pin0_o(pin0),
        .ext_irq_pin1_o(pin1), .irq_pending_o(irqp));
    task stop_test;
        begin
            $display("checks %0d miscompares %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wb(input [7:0] a, input w, input [3:0] s, input [7:0] d);
        integer k;
        begin
            @(posedge clk_i);
            cyc_i <= 1'b1;
            stb_i <= 1'b1;
            we_i <= w;
            adr_i <= a;
            sel_i <= s;
            dat_i <= {24'h0, d};
            k = 0;
            @(posedge clk_i);
            while (ack_o !== 1'b1 && k < 50) begin
                @(posedge clk_i);
                k = k + 1;
            end
            q = dat_o;
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
            if (k == 50) begin
                check(32'h0, 32'h1);
                stop_test;
            end
        end
    endtask
    task req(input r, input irq, input p0, input p1);
        begin
            @(posedge clk_i);
            rq_rst <= r;
            rq_irq <= irq;
            rq_p0 <= p0;
            rq_p1 <= p1;
        end
    endtask
    task skip(input integer c);
        begin
            repeat (c) @(posedge clk_i);
            #1;
        end
    endtask
    task wait_mode(input [1:0] m);
        begin
            n = 0;
            while (mode_o !== m && n < 100) begin
                skip(1);
                n = n + 1;
            end
            check({30'h0, mode_o}, {30'h0, m});
            if (n == 100) stop_test;
        end
    endtask
    initial begin
        rows[0] = {8'h87, 1'b0, 4'h1, 8'h00, 8'h00};
        rows[1] = {8'h88, 1'b0, 4'h1, 8'h00, 8'h00};
        rows[2] = {8'h87, 1'b1, 4'h1, 8'h0C, 8'h00};
        rows[3] = {8'h87, 1'b0, 4'h1, 8'h00, 8'h0C};
        rows[4] = {8'h87, 1'b1, 4'h0, 8'h03, 8'h00};
        rows[5] = {8'h87, 1'b0, 4'h1, 8'h00, 8'h0C};
        rows[6] = {8'h8A, 1'b0, 4'h1, 8'h00, 8'h00};
        rows[7] = {8'h89, 1'b0, 4'h1, 8'h00, 8'h00};
        skip(15);
        check({25'h0, mode_o, cpu_en, osc_en, latch, p0_oe, ack_o}, 32'h1A);
        $display("test reset done");
        req(0, 0, 0, 0);
        rst_i <= 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            wb(rows[i][28:21], rows[i][20], rows[i][19:16], rows[i][15:8]);
            if (!rows[i][20]) check(q, {24'h0, rows[i][7:0]});
        end
        $display("test registers done");
        wb(8'h87, 1'b1, 4'h1, 8'h0D);
        wait_mode(`MODE_IDLE);
        check({26'h0, cpu_en, per_en, latch, strobe, p0_oe, p2_sel}, 32'h1D);
        wb(8'h87, 1'b0, 4'h1, 8'h00);
        check(q, 32'h0C);
        req(0, 1, 0, 0);
        skip(6);
        check({30'h0, mode_o}, 32'h1);
        wb(8'h88, 1'b1, 4'h1, 8'h80);
        wait_mode(`MODE_RUN);
        req(0, 0, 0, 0);
        $display("test idle done");
        wb(8'h88, 1'b1, 4'h1, 8'h91);
        wb(8'h87, 1'b1, 4'h1, 8'h0E);
        wait_mode(`MODE_PDOWN);
        req(0, 0, 0, 1);
        skip(8);
        check({30'h0, mode_o}, 32'h2);
        req(0, 0, 1, 0);
        wait_mode(`MODE_SETTLE);
        i = 0;
        while (mode_o === `MODE_SETTLE && i < 100) begin
            skip(1);
            i = i + 1;
        end
        check(i, SETTLE);
        skip(3);
        check({30'h0, seen1, seen0}, 32'h1);
        req(0, 0, 0, 0);
        $display("test pin wake done");
        wb(8'h88, 1'b1, 4'h1, 8'h82);
        wb(8'h87, 1'b1, 4'h1, 8'h0E);
        wait_mode(`MODE_PDOWN);
        req(0, 0, 0, 1);
        skip(8);
        check({30'h0, mode_o}, 32'h2);
        req(1, 0, 0, 0);
        req(0, 0, 0, 0);
        wait_mode(`MODE_RUN);
        skip(2);
        check({31'h0, core_rst}, 32'h1);
        for (n = 0; rpin !== 1'b0 && n < 100; n = n + 1)
            skip(1);
        check({31'h0, rpin}, 32'h0);
        wb(8'h89, 1'b0, 4'h1, 8'h00);
        check(q, 32'h40);
        wb(8'h87, 1'b0, 4'h1, 8'h00);
        check(q, 32'h0C);
        ext_mem <= 1'b0;
        wb(8'h87, 1'b1, 4'h1, 8'h01);
        wait_mode(`MODE_IDLE);
        check({27'h0, forced, latch, strobe, p0_oe, p2_sel}, 32'h1E);
        req(1, 0, 0, 0);
        req(0, 0, 0, 0);
        wait_mode(`MODE_RUN);
        for (n = 0; rpin !== 1'b0 && n < 100; n = n + 1)
            skip(1);
        check({31'h0, rpin}, 32'h0);
        $display("test reset pin done");
        stop_test;
    end
endmodule // test_power_mode_unit
